// file: hw/adc_ctrl_defines.vh
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ==========================================================
// register byte addresses
`define ADDR_GAIN      12'h000
`define ADDR_POWER     12'h004
`define ADDR_OUTPUT    12'h008
`define ADDR_LVDS      12'h00C
`define ADDR_STATUS    12'h010
`define ADDR_SAMPLE    12'h014

// ==========================================================
// gain register fields
`define GAIN_COARSE_BIT   0
`define GAIN_FINE_LSB     4
`define GAIN_FINE_MAX     3'h6
// power register fields
`define PWR_STBY_BIT      0
`define PWR_OBUF_BIT      1
`define PWR_USE_REG_BIT   2
// output register fields
`define OUT_LVDS_BIT      0
`define OUT_USE_REG_BIT   1
`define OUT_CLKDLY_BIT    2
`define OUT_STRONG_BIT    3
`define OUT_TWOS_BIT      4
`define OUT_FMT_REG_BIT   5
// lvds register fields
`define LVDS_CUR_LSB      0
`define LVDS_DOUBLE_BIT   2
`define LVDS_DTERM_LSB    4
`define LVDS_CTERM_LSB    8

// ==========================================================
// reset values
`define RST_GAIN          32'h0000_0000
`define RST_POWER         32'h0000_0000
`define RST_OUTPUT        32'h0000_0000
`define RST_LVDS          32'h0000_0000

// ==========================================================
// power states
`define PS_NORMAL         2'h0
`define PS_STANDBY        2'h1
`define PS_OBUF_OFF       2'h2
`define PS_GLOBAL_PD      2'h3

// ==========================================================
// timing (clock period 8 ns)
`define CLK_PERIOD_NS     8
`define WAKE_SLOW_US      50
`define WAKE_LVDS_NS      500
`define WAKE_CMOS_NS      200
`define WAKE_SLOW_CYC     ((`WAKE_SLOW_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_LVDS_CYC     (`WAKE_LVDS_NS / `CLK_PERIOD_NS)
`define WAKE_CMOS_CYC     (`WAKE_CMOS_NS / `CLK_PERIOD_NS)
// cycles of pin sync, reload and valid register before data shows
`define WAKE_MARGIN_CYC   5
// clock stop: sampling rate below 1 MSPS = 1000 ns without an edge
`define STOP_LIMIT_NS     1000
`define STOP_LIMIT_CYC    (`STOP_LIMIT_NS / `CLK_PERIOD_NS)
`define LATENCY_CYC       9

`endif

// file: hw/adc_output_and_power_control.v
`timescale 1ns/1ps
// How it works
// - coarse gain bit selects fixed 3.5 dB
// - fine gain field, 0 to 6 dB
// - reset leaves all gain at zero
// - two pins decode four power states
// - two register bits decode same states
// - global power down floats every output
// - global power down wake within 50 us
// - standby wakes within 50 us
// - driver off floats data; 500/200 ns wake
// - slow sampling clock enters clock-stop state
// - 14-bit word plus forwarded clock
// - format chosen by register or pin
// - cmos drives one pin per bit
// - delay bit shifts forwarded clock later
// - strength bit raises cmos drive
// - lvds: seven pairs, two bits each
// - even bits rising, odd bits falling
// - lvds current field, default 3.5 mA
// - doubling bit doubles lvds current
// - separate three-resistor termination selects
// - nine-cycle pipeline latency
// - two's complement or offset binary
`include "adc_ctrl_defines.vh"

module adc_output_and_power_control (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // sampling clock and converted samples
    input wire sample_clk,
    input wire [13:0] sample_word,
    // parallel configuration pins
    input wire serial_data_pin,
    input wire pdn_pin,
    input wire serial_enable_pin,
    // data and clock outputs
    output reg [13:0] data_out,
    output reg [13:0] data_oe,
    output reg forwarded_output_clock,
    output reg forwarded_clock_true_leg,
    output reg clock_oe,
    output reg data_valid,
    // analog and driver controls
    output reg coarse_gain_en,
    output reg [2:0] fine_gain,
    output reg core_power_en,
    output reg ref_power_en,
    output reg output_clock_delay_bit,
    output reg strong_drive,
    output reg lvds_mode,
    output reg [1:0] lvds_current,
    output reg current_double,
    output reg [2:0] data_lane_resistor_select,
    output reg [2:0] clock_lane_resistor_select
);

    // ======================================================
    // configuration registers
    reg [31:0] gain_reg;
    reg [31:0] power_reg;
    reg [31:0] output_reg;
    reg [31:0] lvds_reg;

    // ======================================================
    // synchronisers for foreign inputs
    reg [2:0] sync1_reg; // first stage: pins
    reg [2:0] sync2_reg; // second stage
    reg sclk_s1_reg; // sampling clock first stage
    reg sclk_s2_reg; // sampling clock second stage
    reg sclk_s3_reg; // previous value for edges
    reg [13:0] word_s1_reg;
    reg [13:0] word_s2_reg;

    // two flops per foreign input; the third clock stage
    // feeds the edge detector and the delayed forwarded clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            word_s1_reg <= 14'h0000;
            word_s2_reg <= 14'h0000;
        end else begin
            sync1_reg <= {serial_enable_pin, serial_data_pin, pdn_pin};
            sync2_reg <= sync1_reg;
            sclk_s1_reg <= sample_clk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            word_s1_reg <= sample_word;
            word_s2_reg <= word_s1_reg;
        end
    end

    // sampling clock edges
    wire rise = sclk_s2_reg & ~sclk_s3_reg;
    wire fall = ~sclk_s2_reg & sclk_s3_reg;

    // ======================================================
    // mode decode
    // override bits pick register fields over the pins
    // format pin chooses both interface and coding
    wire use_reg_pwr = power_reg[`PWR_USE_REG_BIT];
    // pin order: {first pin, second pin}
    wire [1:0] pin_state = {sync2_reg[1], sync2_reg[0]};
    wire [1:0] reg_state = {power_reg[`PWR_OBUF_BIT],
                            power_reg[`PWR_STBY_BIT]};
    wire [1:0] pstate = use_reg_pwr ? reg_state : pin_state;
    wire lvds_sel = output_reg[`OUT_USE_REG_BIT] ?
                    output_reg[`OUT_LVDS_BIT] : sync2_reg[2];
    wire twos_sel = output_reg[`OUT_FMT_REG_BIT] ?
                    output_reg[`OUT_TWOS_BIT] : sync2_reg[2];

    // ======================================================
    // clock stop detection
    reg [7:0] idle_cnt_reg;
    reg clk_stopped_reg;

    // counts pclk cycles since the last sampling rise; a gap
    // longer than the limit means the rate fell too low
    // starts stopped so no data is valid before a first rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_reg <= 8'h00;
            clk_stopped_reg <= 1'b1;
        end else if (rise) begin
            idle_cnt_reg <= 8'h00;
            clk_stopped_reg <= 1'b0;
        end else if (idle_cnt_reg >= `STOP_LIMIT_CYC) begin
            clk_stopped_reg <= 1'b1;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 8'h01;
        end
    end

    // ======================================================
    // wake-up timer
    reg [1:0] pstate_reg;
    reg stopped_prev_reg;
    reg [13:0] wake_cnt_reg;
    // reload values trimmed by the pin sync, reload and valid
    // register cycles so valid data is never late
    localparam [31:0] slow_load = `WAKE_SLOW_CYC - `WAKE_MARGIN_CYC;
    localparam [31:0] lvds_load = `WAKE_LVDS_CYC - `WAKE_MARGIN_CYC;
    localparam [31:0] cmos_load = `WAKE_CMOS_CYC - `WAKE_MARGIN_CYC;

    // any low-power state reloads the count; it runs down
    // only in normal mode with the sampling clock alive
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pstate_reg <= `PS_NORMAL;
            stopped_prev_reg <= 1'b1;
            wake_cnt_reg <= slow_load[13:0];
        end else begin
            pstate_reg <= pstate;
            stopped_prev_reg <= clk_stopped_reg;
            if (pstate != `PS_NORMAL || clk_stopped_reg) begin
                wake_cnt_reg <= slow_load[13:0];
            end else if (pstate_reg == `PS_OBUF_OFF) begin
                // driver-off exit: short wake, by output format
                wake_cnt_reg <= lvds_sel ? lvds_load[13:0] :
                                cmos_load[13:0];
            end else if (pstate_reg != `PS_NORMAL || stopped_prev_reg) begin
                wake_cnt_reg <= slow_load[13:0];
            end else if (wake_cnt_reg != 14'h0000) begin
                wake_cnt_reg <= wake_cnt_reg - 14'h0001;
            end
        end
    end

    // ======================================================
    // conversion pipeline, one stage per sampling rise
    // latency is counted in sampling rises, not pclk cycles
    reg [13:0] pipe_reg [0:`LATENCY_CYC-1];
    genvar g;
    generate
        for (g = 0; g < `LATENCY_CYC; g = g + 1) begin : stage
            wire [13:0] stage_in; // what this stage takes on a rise
            if (g == 0) begin : head
                // first stage takes the synchronised sample
                assign stage_in = word_s2_reg;
            end else begin : tail
                // later stages shift the word one step on
                assign stage_in = pipe_reg[g-1];
            end
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pipe_reg[g] <= 14'h0000;
                end else if (rise) begin
                    pipe_reg[g] <= stage_in;
                end
            end
        end
    endgenerate

    // coded word: offset binary flips msb for two's complement
    wire [13:0] out_word = pipe_reg[`LATENCY_CYC-1] ^
                           {twos_sel, 13'h0000};
    // ddr lane words: even lanes from the fresh word at the
    // rise, odd lanes from the word held at that rise
    reg [13:0] hold_word_reg;
    wire [6:0] even_bits; // lanes for the rising half
    wire [6:0] odd_bits; // lanes for the falling half
    generate
        for (g = 0; g < 7; g = g + 1) begin : lane
            assign even_bits[g] = out_word[2*g];
            assign odd_bits[g] = hold_word_reg[2*g+1];
        end
    endgenerate

    // ======================================================
    // output drive
    // data and forwarded clock leave on one pclk edge unless the
    // delay bit holds the clock one edge later; the receiver ages the clock edge before it captures
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_word_reg <= 14'h0000;
            data_out <= 14'h0000;
            data_oe <= 14'h0000;
            forwarded_output_clock <= 1'b0;
            forwarded_clock_true_leg <= 1'b0;
            clock_oe <= 1'b0;
            data_valid <= 1'b0;
        end else begin
            // global power down floats all, driver off floats data
            data_oe <= (pstate == `PS_NORMAL || pstate == `PS_STANDBY) ?
                       (lvds_sel ? 14'h007F : 14'h3FFF) : 14'h0000;
            clock_oe <= (pstate != `PS_GLOBAL_PD);
            data_valid <= (pstate == `PS_NORMAL) && !clk_stopped_reg &&
                          (wake_cnt_reg == 14'h0000);
            // clock follows sampling clock, one tick later with the delay bit
            forwarded_output_clock <= output_reg[`OUT_CLKDLY_BIT] ?
                                      sclk_s3_reg : sclk_s2_reg;
            forwarded_clock_true_leg <= output_reg[`OUT_CLKDLY_BIT] ?
                                        sclk_s3_reg : sclk_s2_reg;
            if (rise) begin
                hold_word_reg <= out_word;
            end
            if (!lvds_sel) begin
                if (rise) begin
                    data_out <= out_word;
                end
            end else if (rise) begin
                // rising half carries the even bits
                data_out <= {7'h00, even_bits};
            end else if (fall) begin
                // falling half carries the odd bits
                data_out <= {7'h00, odd_bits};
            end
        end
    end

    // ======================================================
    // static controls
    // registered copies of the fields and the decoded state
    // analog side sees only settled flop outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_gain_en <= 1'b0;
            fine_gain <= 3'h0;
            core_power_en <= 1'b0;
            ref_power_en <= 1'b0;
            output_clock_delay_bit <= 1'b0;
            strong_drive <= 1'b0;
            lvds_mode <= 1'b0;
            lvds_current <= 2'h0;
            current_double <= 1'b0;
            data_lane_resistor_select <= 3'h0;
            clock_lane_resistor_select <= 3'h0;
        end else begin
            coarse_gain_en <= gain_reg[`GAIN_COARSE_BIT];
            fine_gain <= gain_reg[`GAIN_FINE_LSB+2:`GAIN_FINE_LSB];
            core_power_en <= (pstate == `PS_NORMAL ||
                              pstate == `PS_OBUF_OFF) &&
                             !clk_stopped_reg;
            ref_power_en <= (pstate != `PS_GLOBAL_PD);
            output_clock_delay_bit <= output_reg[`OUT_CLKDLY_BIT];
            strong_drive <= output_reg[`OUT_STRONG_BIT];
            lvds_mode <= lvds_sel;
            lvds_current <= lvds_reg[`LVDS_CUR_LSB+1:`LVDS_CUR_LSB];
            current_double <= lvds_reg[`LVDS_DOUBLE_BIT];
            data_lane_resistor_select <=
                lvds_reg[`LVDS_DTERM_LSB+2:`LVDS_DTERM_LSB];
            clock_lane_resistor_select <=
                lvds_reg[`LVDS_CTERM_LSB+2:`LVDS_CTERM_LSB];
        end
    end

    // ======================================================
    // apb register access, zero wait states
    // pready follows the setup cycle, so the access phase
    // always lasts exactly one cycle
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite && pready;
    wire mapped = (paddr == `ADDR_GAIN) || (paddr == `ADDR_POWER) ||
                  (paddr == `ADDR_OUTPUT) || (paddr == `ADDR_LVDS) ||
                  (paddr == `ADDR_STATUS) || (paddr == `ADDR_SAMPLE);

    // writes land at the access edge; status, sample and
    // unmapped offsets leave every register as it was
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_reg <= `RST_GAIN;
            power_reg <= `RST_POWER;
            output_reg <= `RST_OUTPUT;
            lvds_reg <= `RST_LVDS;
        end else if (wr) begin
            case (paddr)
                `ADDR_GAIN: begin
                    // fine values above 6 dB clamp to 6 dB
                    gain_reg <= {25'h0,
                        (pwdata[6:4] > `GAIN_FINE_MAX) ?
                        `GAIN_FINE_MAX : pwdata[6:4],
                        3'h0, pwdata[0]};
                end
                `ADDR_POWER: begin
                    power_reg <= {29'h0, pwdata[2:0]};
                end
                `ADDR_OUTPUT: begin
                    output_reg <= {26'h0, pwdata[5:0]};
                end
                `ADDR_LVDS: begin
                    lvds_reg <= {21'h0, pwdata[10:8], 1'b0,
                                 pwdata[6:4], 1'b0, pwdata[2:0]};
                end
                default: begin
                    gain_reg <= gain_reg; // read-only or unmapped
                end
            endcase
        end
    end

    // ready in access phase, read data set up on setup cycle
    // unmapped offsets answer with an error and zero data
    // prdata holds until the next setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                case (paddr)
                    `ADDR_GAIN: prdata <= gain_reg;
                    `ADDR_POWER: prdata <= power_reg;
                    `ADDR_OUTPUT: prdata <= output_reg;
                    `ADDR_LVDS: prdata <= lvds_reg;
                    `ADDR_STATUS: prdata <= {25'h0, lvds_sel,
                        clk_stopped_reg, data_valid, 2'h0, pstate};
                    `ADDR_SAMPLE: prdata <= {18'h0, out_word};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// file: sim/adc_ctrl_props.sv
`timescale 1ns/1ps
// ==========================================
// port checker for output and power control
module adc_ctrl_props (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb handshake
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // observed outputs
    input wire [13:0] data_oe,
    input wire clock_oe,
    input wire data_valid,
    input wire forwarded_output_clock,
    input wire forwarded_clock_true_leg,
    input wire coarse_gain_en,
    input wire [2:0] fine_gain,
    input wire core_power_en,
    input wire ref_power_en,
    input wire lvds_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // full power down floats all and stops core
    property p_gpd_float;
        !clock_oe |-> data_oe == 14'h0000 && !core_power_en && !ref_power_en;
    endproperty
    a_gpd_float: assert property (p_gpd_float)
        else $error("power down leaves outputs driven");
    // enable pattern follows the output format
    property p_oe_shape;
        data_oe != 14'h0000 |-> data_oe == (lvds_mode ? 14'h007F : 14'h3FFF);
    endproperty
    a_oe_shape: assert property (p_oe_shape)
        else $error("output enable pattern wrong");
    // no valid data with core off
    property p_core_off_invalid;
        !core_power_en |-> !data_valid;
    endproperty
    a_core_off_invalid: assert property (p_core_off_invalid)
        else $error("valid while core off");
    // no valid data with drivers off
    property p_oe_off_invalid;
        data_oe == 14'h0000 |-> !data_valid;
    endproperty
    a_oe_off_invalid: assert property (p_oe_off_invalid)
        else $error("valid while drivers off");
    // fine gain never beyond its top step
    property p_fine_max;
        fine_gain <= 3'h6;
    endproperty
    a_fine_max: assert property (p_fine_max)
        else $error("fine gain above top step");
    // gain cleared straight after reset
    property p_reset_gain;
        $rose(presetn) |-> !coarse_gain_en && fine_gain == 3'h0;
    endproperty
    a_reset_gain: assert property (p_reset_gain)
        else $error("gain not cleared by reset");
    // access phase answered in one cycle, one-cycle pulse
    property p_apb_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("bus answer late or stuck");
    // error only together with ready
    property p_slverr;
        pslverr |-> pready && $past(psel);
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error outside access phase");
    // both clock legs carry the same clock
    property p_legs;
        forwarded_clock_true_leg == forwarded_output_clock;
    endproperty
    a_legs: assert property (p_legs)
        else $error("clock legs differ");
endmodule

bind adc_output_and_power_control adc_ctrl_props props_u (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .data_oe, .clock_oe, .data_valid,
    .forwarded_output_clock, .forwarded_clock_true_leg, .coarse_gain_en,
    .fine_gain, .core_power_en, .ref_power_en, .lvds_mode);

// file: sim/rx_capture_model.sv
`timescale 1ns/1ps
// ==========================================
// receiver capturing with the forwarded clock
module rx_capture_model (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // link from the converter
    input wire [13:0] data_out,
    input wire forwarded_output_clock,
    input wire forwarded_clock_true_leg,
    input wire lvds_mode,
    // recovered word
    output reg [13:0] word_seen
);
    reg ck_q; // last clock level
    reg [2:0] rise_d; // rises aged for setup margin
    reg [2:0] fall_d; // falls aged for setup margin
    integer i;
    wire ck = lvds_mode ? forwarded_clock_true_leg : forwarded_output_clock;
    // find edges, capture three cycles later
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_q <= 1'b0;
            rise_d <= 3'h0;
            fall_d <= 3'h0;
            word_seen <= 14'h0000;
        end else begin
            ck_q <= ck;
            rise_d <= {rise_d[1:0], ck & ~ck_q};
            fall_d <= {fall_d[1:0], ~ck & ck_q};
            if (rise_d[2] && !lvds_mode)
                word_seen <= data_out;
            for (i = 0; i < 7; i = i + 1) begin
                if (rise_d[2] && lvds_mode)
                    word_seen[2*i] <= data_out[i];
                if (fall_d[2] && lvds_mode)
                    word_seen[2*i+1] <= data_out[i];
            end
        end
    end
endmodule

// file: sim/adc_output_and_power_control_test.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
// ==========================================
// bench for output and power control
module adc_output_and_power_control_test;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg sample_clk = 0, sclk_run = 1; // link clock and its gate
    reg [13:0] sample_word = 0;
    reg serial_data_pin = 0, pdn_pin = 0, serial_enable_pin = 0;
    wire [31:0] prdata;
    wire [13:0] data_out, data_oe, word_seen;
    wire pready, pslverr, forwarded_output_clock, forwarded_clock_true_leg;
    wire clock_oe, data_valid, coarse_gain_en, core_power_en, ref_power_en;
    wire output_clock_delay_bit, strong_drive, lvds_mode, current_double;
    wire [2:0] fine_gain, data_lane_resistor_select;
    wire [2:0] clock_lane_resistor_select;
    wire [1:0] lvds_current;
    int miscompares = 0, num_checks = 0, cyc = 0, i, n;
    int seed = 32'hbc8e;
    logic [31:0] r, v;
    logic [13:0] w;
    logic [64:0] q[$]; // expected {err, mask, data}
    logic [64:0] e;
    int lim[2] = '{25, 62}; // driver wake bound: 200 ns cmos, 500 ns lvds
    adc_output_and_power_control dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_clk,
        .sample_word, .serial_data_pin, .pdn_pin, .serial_enable_pin,
        .data_out, .data_oe, .forwarded_output_clock,
        .forwarded_clock_true_leg, .clock_oe, .data_valid, .coarse_gain_en,
        .fine_gain, .core_power_en, .ref_power_en, .output_clock_delay_bit,
        .strong_drive, .lvds_mode, .lvds_current, .current_double,
        .data_lane_resistor_select, .clock_lane_resistor_select);
    rx_capture_model rx_u (.pclk, .presetn, .data_out,
        .forwarded_output_clock, .forwarded_clock_true_leg, .lvds_mode,
        .word_seen);
    // clocks; link clock stands while gated
    always #4 pclk = ~pclk;
    always #62.5 if (sclk_run) sample_clk = ~sample_clk;
    // ==========================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one apb transfer; read data rides in d
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic er);
        @(posedge pclk);
        q.push_back({er, m, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task pause(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask
    // wait for valid data, bounded by lim
    task wake(input int l);
        n = 0;
        while (data_valid !== 1'b1 && n < 7000) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n <= l), 32'h1);
    endtask
    // bus answer monitor takes the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1) begin
            e = q.pop_front();
            check({31'h0, pslverr}, {31'h0, e[64]});
            check(prdata & e[63:32], e[31:0] & e[63:32]);
        end
    // run-length guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            test_done;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++)
            apb(1'b0, 12'(i * 4), 32'h0, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, 12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 12'h024, 32'h1, 32'h0, 1'b1);
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            wr(`ADDR_GAIN, {25'h0, i[2:0], 3'h0, r[0]});
            pause(2);
            check(32'(coarse_gain_en), 32'(r[0]));
            check(32'(fine_gain), i > 6 ? 6 : i);
        end
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            v = {21'h0, r[10:8], 1'b0, r[6:4], 1'b0, r[2], i[1:0]};
            wr(`ADDR_LVDS, v);
            apb(1'b0, `ADDR_LVDS, v, 32'h777, 1'b0);
            pause(2);
            check(32'(lvds_current), i);
            check(32'(current_double), 32'(r[2]));
            check(32'(data_lane_resistor_select), 32'(r[6:4]));
            check(32'(clock_lane_resistor_select), 32'(r[10:8]));
        end
        for (i = 0; i < 4; i++) begin
            wr(`ADDR_POWER, 32'h4 | i);
            apb(1'b0, `ADDR_STATUS, i, 32'h3, 1'b0);
            pause(2);
            check(32'(core_power_en), 32'(!i[0]));
            check(32'(ref_power_en), 32'(i != 3));
            check(32'(clock_oe), 32'(i != 3));
            if (i[1])
                check(32'(data_oe), 32'h0);
        end
        wr(`ADDR_POWER, 32'h0);
        for (i = 0; i < 4; i++) begin
            @(posedge pclk);
            serial_data_pin <= i[1];
            pdn_pin <= i[0];
            pause(8);
            apb(1'b0, `ADDR_STATUS, i, 32'h3, 1'b0);
        end
        @(posedge pclk);
        serial_data_pin <= 1'b0;
        pdn_pin <= 1'b0;
        r = $random(seed);
        w = r[13:0];
        sample_word <= w;
        wr(`ADDR_OUTPUT, 32'h22);
        wake(6250);
        pause(300);
        check(32'(word_seen), 32'(w));
        check(32'(data_oe), 32'h3FFF);
        check(32'(lvds_mode), 32'h0);
        wr(`ADDR_OUTPUT, 32'h32);
        pause(300);
        check(32'(word_seen), 32'(w ^ 14'h2000));
        @(posedge pclk);
        r = $random(seed);
        w = r[13:0];
        sample_word <= w;
        serial_enable_pin <= 1'b1;
        wr(`ADDR_OUTPUT, 32'h0C);
        pause(300);
        check(32'(data_oe), 32'h007F);
        check(32'(lvds_mode), 32'h1);
        check(32'(word_seen), 32'(w ^ 14'h2000));
        check(32'(output_clock_delay_bit), 32'h1);
        check(32'(strong_drive), 32'h1);
        for (i = 1; i >= 0; i--) begin
            @(posedge pclk);
            serial_enable_pin <= i[0];
            pause(300);
            wr(`ADDR_POWER, 32'h6);
            pause(4);
            check(32'(data_valid), 32'h0);
            wr(`ADDR_POWER, 32'h4);
            wake(lim[i]);
        end
        wr(`ADDR_POWER, 32'h5);
        pause(4);
        check(32'(data_valid), 32'h0);
        wr(`ADDR_POWER, 32'h4);
        wake(6250);
        @(posedge pclk);
        sclk_run <= 1'b0;
        pause(200);
        apb(1'b0, `ADDR_STATUS, 32'h20, 32'h30, 1'b0);
        sclk_run <= 1'b1;
        wake(6300);
        pause(4);
        test_done;
    end
endmodule
